// file: codec_cfg_pkg.sv
// Purpose: Constants for the per-channel line codec configuration block
// Assumes: Commands arrive already framed as command byte plus data byte
// Notes: Rising-edge launch is legal only once the PCM delay is removed
// Notes on behaviour
// R01: 42h writes receive highway and time slot
// R02: 43h reads receive highway and slot
// R03: 44h stores clock slots and edge bit
// R04: Edge bit picks PCM launch clock edge
// R05: Edge bit is shared by both channels
// R06: Host sets rising edge only with delay removed
// R07: Reserved bits written zero, read undefined
// R08: 45h reads clock slots and edge bit
// R09: 50h stores delay, gains, impedance code
// R10: Gain and loss selects give 6.02 dB
// R11: Impedance gain is 0.0625 times code minus 16
// R12: Code 10000 loopback, 00000 cuts network
// R13: PCM clock limited to 4.096 MHz then
// R14: 51h reads delay, gains and impedance code
// R15: 52h latches pin outputs, driven when output
// R16: 53h reads live pin levels
// R17: 54h sets each pin direction, default input
// R18: Host sets unused pins as outputs
// R19: 55h reads power flag, activity, directions
// R20: Activity bit is zero in standby
// R21: 60h selects balance mode and companding law
// R22: 60h bits 5..2 enable four filters
// R23: Bits 1..0 enable impedance and balance filters
// R24: Every setting kept per channel, except edge
package codec_cfg_pkg;
  localparam logic [7:0] CMD_WR_RX_SLOT = 8'h42;
  localparam logic [7:0] CMD_RD_RX_SLOT = 8'h43;
  localparam logic [7:0] CMD_WR_CLK_SLOT = 8'h44;
  localparam logic [7:0] CMD_RD_CLK_SLOT = 8'h45;
  localparam logic [7:0] CMD_WR_DELAY_GAIN = 8'h50;
  localparam logic [7:0] CMD_RD_DELAY_GAIN = 8'h51;
  localparam logic [7:0] CMD_WR_PIN_LATCH = 8'h52;
  localparam logic [7:0] CMD_RD_PIN_LEVELS = 8'h53;
  localparam logic [7:0] CMD_WR_PIN_DIR = 8'h54;
  localparam logic [7:0] CMD_RD_DIR_STATUS = 8'h55;
  localparam logic [7:0] CMD_WR_OP_FUNC = 8'h60;
  localparam logic [7:0] CMD_RD_OP_FUNC = 8'h61;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h02;
  localparam logic [7:0] CMD_DEACTIVATE = 8'h00;
  localparam logic [7:0] CMD_ACTIVATE = 8'h0E;
  localparam int NUM_CHANNELS = 2;
  localparam int NUM_LINE_PINS = 5;
  localparam int EDGE_BIT = 6;
  localparam int RX_SLOT_LSB = 3;
  localparam int TX_SLOT_LSB = 0;
  localparam int SLOT_W = 3;
  localparam int DELAY_BIT = 7;
  localparam int TX_GAIN_BIT = 6;
  localparam int RX_LOSS_BIT = 5;
  localparam int IMP_W = 5;
  localparam int POWER_FLAG_BIT = 7;
  localparam int ACTIVITY_BIT = 6;
  localparam int ADAPTIVE_BIT = 7;
  localparam int LAW_BIT = 6;
  localparam int RX_GAIN_EN_BIT = 5;
  localparam int TX_GAIN_EN_BIT = 4;
  localparam int TX_EQ_EN_BIT = 3;
  localparam int RX_EQ_EN_BIT = 2;
  localparam int IMP_EN_BIT = 1;
  localparam int BAL_EN_BIT = 0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [4:0] IMP_CODE_LOOPBACK = 5'h10;
  localparam logic [4:0] IMP_CODE_CUTOFF = 5'h00;
  localparam logic [5:0] IMP_OFFSET = 6'h10;
  typedef enum logic [1:0] {IMP_GAIN, IMP_LOOPBACK, IMP_CUT} imp_mode_t;
endpackage

// file: pin_sync.sv
`timescale 1ns/1ps
// Purpose: Two-flop synchroniser for the line-control pin inputs
// Assumes: Pin levels are asynchronous to REF_CLK
// Notes: First stage feeds only the second
module pin_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// file: pcm_launch.sv
`timescale 1ns/1ps
// Purpose: Picks the PCM clock edge on which transmit data launches
// Assumes: PCM clock sampled on REF_CLK after synchronising
// Notes: Edges are seen two REF_CLK cycles late
module pcm_launch (
  input wire logic clk,
  input wire logic rst,
  input wire logic pcm_clk_in,
  input wire logic rising_sel,
  output logic launch
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pcm_clk_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
  // R04: edge choice
  assign launch = rising_sel ? (sync_reg & ~prev_reg) : (~sync_reg & prev_reg);
endmodule

// file: line_codec_config_commands.sv
`timescale 1ns/1ps
// Purpose: Per-channel configuration and status behind the host command port
// Assumes: One command per strobe, data byte alongside; reads answer next cycle
// Notes: Pin outputs are driven with low-active enables
module line_codec_config_commands (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CMD_VALID,
  input wire logic CMD_CHANNEL,
  input wire logic [7:0] CMD_CODE,
  input wire logic [7:0] CMD_WDATA,
  output logic [7:0] CMD_RDATA,
  output logic CMD_RVALID,
  input wire logic POWER_LOSS_EVENT,
  input wire logic [codec_cfg_pkg::NUM_LINE_PINS-1:0] LINE_PIN_CH0_IN,
  output logic [codec_cfg_pkg::NUM_LINE_PINS-1:0] LINE_PIN_CH0_OUT,
  output logic [codec_cfg_pkg::NUM_LINE_PINS-1:0] LINE_PIN_CH0_OE_N,
  input wire logic [codec_cfg_pkg::NUM_LINE_PINS-1:0] LINE_PIN_CH1_IN,
  output logic [codec_cfg_pkg::NUM_LINE_PINS-1:0] LINE_PIN_CH1_OUT,
  output logic [codec_cfg_pkg::NUM_LINE_PINS-1:0] LINE_PIN_CH1_OE_N,
  input wire logic PCM_CLK,
  output logic PCM_TX_LAUNCH,
  output logic TRANSMIT_EDGE_SELECT,
  output logic [1:0] CHANNEL_ACTIVE,
  output logic [1:0] DELAY_REMOVED,
  output logic [1:0] TX_GAIN_6DB,
  output logic [1:0] RX_LOSS_6DB,
  output logic [11:0] IMP_GAIN_CH0,
  output logic [11:0] IMP_GAIN_CH1,
  output logic [1:0] IMP_LOOPBACK,
  output logic [1:0] IMP_CUTOFF,
  output logic [1:0] ADAPTIVE_ACTIVE,
  output logic [7:0] OP_FUNC_CH0,
  output logic [7:0] OP_FUNC_CH1,
  output logic [7:0] RX_SLOT_CH0,
  output logic [7:0] RX_SLOT_CH1
);
  import codec_cfg_pkg::*;

  logic [7:0] rx_slot_reg [NUM_CHANNELS];
  logic [RX_SLOT_LSB+SLOT_W-1:0] clk_slot_reg [NUM_CHANNELS];
  logic transmit_edge_select_reg;
  logic [7:0] delay_gain_reg [NUM_CHANNELS];
  logic [NUM_LINE_PINS-1:0] pin_latch_reg [NUM_CHANNELS];
  logic [NUM_LINE_PINS-1:0] pin_dir_reg [NUM_CHANNELS];
  logic [7:0] op_func_reg [NUM_CHANNELS];
  logic power_flag_reg [NUM_CHANNELS];
  logic active_reg [NUM_CHANNELS];
  logic [NUM_LINE_PINS-1:0] pin_level [NUM_CHANNELS];
  logic [7:0] rdata_next;
  logic rd_hit;
  logic [1:0] power_sync_reg;

  pin_sync #(.WIDTH(NUM_LINE_PINS)) u_sync0 (
    .clk(REF_CLK),
    .rst(RST),
    .async_in(LINE_PIN_CH0_IN),
    .sync_out(pin_level[0])
  );
  pin_sync #(.WIDTH(NUM_LINE_PINS)) u_sync1 (
    .clk(REF_CLK),
    .rst(RST),
    .async_in(LINE_PIN_CH1_IN),
    .sync_out(pin_level[1])
  );

  // Power event is asynchronous: two stages, then only the second is read
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      power_sync_reg <= '0;
    end else begin
      power_sync_reg <= {power_sync_reg[0], POWER_LOSS_EVENT};
    end
  end

  // R05: shared edge bit
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      transmit_edge_select_reg <= 1'b0;
    end else if (CMD_VALID && CMD_CODE == CMD_WR_CLK_SLOT) begin
      transmit_edge_select_reg <= CMD_WDATA[EDGE_BIT];
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch = ch + 1) begin : g_chan
      logic sel;
      logic soft_rst;
      assign sel = CMD_VALID && (CMD_CHANNEL == 1'(ch));
      assign soft_rst = sel && CMD_CODE == CMD_SOFT_RESET;

      // R24: per-channel copies
      // R01: receive slot write
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          rx_slot_reg[ch] <= BYTE_RESET;
        end else if (sel && CMD_CODE == CMD_WR_RX_SLOT) begin
          rx_slot_reg[ch] <= CMD_WDATA;
        end
      end

      // R03: clock slot write
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          clk_slot_reg[ch] <= '0;
        end else if (sel && CMD_CODE == CMD_WR_CLK_SLOT) begin
          clk_slot_reg[ch] <= CMD_WDATA[RX_SLOT_LSB+SLOT_W-1:TX_SLOT_LSB];
        end
      end

      // R09: delay gain code write; soft reset clears gains and code
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          delay_gain_reg[ch] <= BYTE_RESET;
        end else if (sel && CMD_CODE == CMD_WR_DELAY_GAIN) begin
          delay_gain_reg[ch] <= CMD_WDATA;
        end else if (soft_rst) begin
          delay_gain_reg[ch] <= {delay_gain_reg[ch][DELAY_BIT], 7'h00};
        end
      end

      // R15: output latch write
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          pin_latch_reg[ch] <= '0;
        end else if (sel && CMD_CODE == CMD_WR_PIN_LATCH) begin
          pin_latch_reg[ch] <= CMD_WDATA[NUM_LINE_PINS-1:0];
        end
      end

      // R17: direction write, soft reset returns to inputs
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          pin_dir_reg[ch] <= '0;
        end else if (sel && CMD_CODE == CMD_WR_PIN_DIR) begin
          pin_dir_reg[ch] <= CMD_WDATA[NUM_LINE_PINS-1:0];
        end else if (soft_rst) begin
          pin_dir_reg[ch] <= '0;
        end
      end

      // R21: mode and law; R22: filter enables; R23: balance enables
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          op_func_reg[ch] <= BYTE_RESET;
        end else if (sel && CMD_CODE == CMD_WR_OP_FUNC) begin
          op_func_reg[ch] <= CMD_WDATA;
        end else if (soft_rst) begin
          op_func_reg[ch] <= BYTE_RESET;
        end
      end

      // R19: sticky flag, event wins over the clearing reset
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          power_flag_reg[ch] <= 1'b1;
        end else if (power_sync_reg[1]) begin
          power_flag_reg[ch] <= 1'b1;
        end else if (soft_rst) begin
          power_flag_reg[ch] <= 1'b0;
        end
      end

      // R20: activity state
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          active_reg[ch] <= 1'b0;
        end else if (sel && CMD_CODE == CMD_ACTIVATE) begin
          active_reg[ch] <= 1'b1;
        end else if (soft_rst || (sel && CMD_CODE == CMD_DEACTIVATE)) begin
          active_reg[ch] <= 1'b0;
        end
      end

      // R10: gain and loss selects
      assign TX_GAIN_6DB[ch] = delay_gain_reg[ch][TX_GAIN_BIT];
      assign RX_LOSS_6DB[ch] = delay_gain_reg[ch][RX_LOSS_BIT];
      assign DELAY_REMOVED[ch] = delay_gain_reg[ch][DELAY_BIT];
      assign CHANNEL_ACTIVE[ch] = active_reg[ch];
      // R12: special codes
      assign IMP_LOOPBACK[ch] = delay_gain_reg[ch][IMP_W-1:0] == IMP_CODE_LOOPBACK;
      assign IMP_CUTOFF[ch] = delay_gain_reg[ch][IMP_W-1:0] == IMP_CODE_CUTOFF;
      // R23: adaptive only with balance filter on
      assign ADAPTIVE_ACTIVE[ch] = op_func_reg[ch][ADAPTIVE_BIT] & op_func_reg[ch][BAL_EN_BIT];
    end
  endgenerate

  // R11: signed code minus 16, in sixteenths; 4 fraction bits
  logic signed [5:0] imp_diff0;
  logic signed [5:0] imp_diff1;
  assign imp_diff0 = signed'({1'b0, delay_gain_reg[0][IMP_W-1:0]} - IMP_OFFSET);
  assign imp_diff1 = signed'({1'b0, delay_gain_reg[1][IMP_W-1:0]} - IMP_OFFSET);
  // R12: cutoff code is zero gain, not minus one
  assign IMP_GAIN_CH0 = IMP_CUTOFF[0] ? '0 : {{6{imp_diff0[5]}}, imp_diff0};
  assign IMP_GAIN_CH1 = IMP_CUTOFF[1] ? '0 : {{6{imp_diff1[5]}}, imp_diff1};

  // R15: drive only while output
  assign LINE_PIN_CH0_OUT = pin_latch_reg[0];
  assign LINE_PIN_CH1_OUT = pin_latch_reg[1];
  assign LINE_PIN_CH0_OE_N = ~pin_dir_reg[0];
  assign LINE_PIN_CH1_OE_N = ~pin_dir_reg[1];

  assign TRANSMIT_EDGE_SELECT = transmit_edge_select_reg;
  assign OP_FUNC_CH0 = op_func_reg[0];
  assign OP_FUNC_CH1 = op_func_reg[1];
  assign RX_SLOT_CH0 = rx_slot_reg[0];
  assign RX_SLOT_CH1 = rx_slot_reg[1];

  // R04: launch edge follows shared select
  pcm_launch u_launch (
    .clk(REF_CLK),
    .rst(RST),
    .pcm_clk_in(PCM_CLK),
    .rising_sel(transmit_edge_select_reg),
    .launch(PCM_TX_LAUNCH)
  );

  // R07: read mux, reserved bits zero
  always_comb begin
    rdata_next = BYTE_RESET;
    rd_hit = 1'b1;
    case (CMD_CODE)
      // R02: receive slot read
      CMD_RD_RX_SLOT: rdata_next = rx_slot_reg[CMD_CHANNEL];
      // R08: clock slot read
      CMD_RD_CLK_SLOT: rdata_next = {1'b0, transmit_edge_select_reg, clk_slot_reg[CMD_CHANNEL]};
      // R14: delay gain read
      CMD_RD_DELAY_GAIN: rdata_next = delay_gain_reg[CMD_CHANNEL];
      // R16: live pin levels
      CMD_RD_PIN_LEVELS: rdata_next = {3'h0, pin_level[CMD_CHANNEL]};
      // R19: status and directions
      CMD_RD_DIR_STATUS: rdata_next = {power_flag_reg[CMD_CHANNEL], active_reg[CMD_CHANNEL],
                                       1'b0, pin_dir_reg[CMD_CHANNEL]};
      CMD_RD_OP_FUNC: rdata_next = op_func_reg[CMD_CHANNEL];
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      CMD_RDATA <= BYTE_RESET;
      CMD_RVALID <= 1'b0;
    end else begin
      CMD_RVALID <= CMD_VALID && rd_hit;
      if (CMD_VALID && rd_hit) begin
        CMD_RDATA <= rdata_next;
      end
    end
  end

  // R05: either channel writes one edge bit
  a_edge_shared: assert property (@(posedge REF_CLK) disable iff (RST) // R05
    CMD_VALID && CMD_CODE == CMD_WR_CLK_SLOT |=>
    TRANSMIT_EDGE_SELECT == $past(CMD_WDATA[EDGE_BIT]))
    else $error("edge select not updated");
  // R02: slot read answers next cycle
  a_read_latency: assert property (@(posedge REF_CLK) disable iff (RST) // R02
    CMD_VALID && CMD_CODE == CMD_RD_RX_SLOT |=> CMD_RVALID &&
    CMD_RDATA == ($past(CMD_CHANNEL) ? $past(RX_SLOT_CH1) : $past(RX_SLOT_CH0)))
    else $error("receive slot read wrong");
  // R17: direction sets enables
  a_pin_drive: assert property (@(posedge REF_CLK) disable iff (RST) // R17
    CMD_VALID && !CMD_CHANNEL && CMD_CODE == CMD_WR_PIN_DIR |=>
    LINE_PIN_CH0_OE_N == ~$past(CMD_WDATA[NUM_LINE_PINS-1:0]))
    else $error("pin direction not applied");
  // R17: soft reset frees pins
  a_soft_dir: assert property (@(posedge REF_CLK) disable iff (RST) // R17
    CMD_VALID && !CMD_CHANNEL && CMD_CODE == CMD_SOFT_RESET |=> LINE_PIN_CH0_OE_N == '1)
    else $error("soft reset left outputs");
  // R19: event sets both flags
  a_flag_sticky: assert property (@(posedge REF_CLK) disable iff (RST) // R19
    power_sync_reg[1] |=> power_flag_reg[0] && power_flag_reg[1])
    else $error("power flag lost");
  // R23: adaptive needs balance filter
  a_adapt_gate: assert property (@(posedge REF_CLK) disable iff (RST) // R23
    !op_func_reg[0][BAL_EN_BIT] |-> !ADAPTIVE_ACTIVE[0])
    else $error("adaptive without balance");
  // R12: loopback code has no gain
  a_loop_code: assert property (@(posedge REF_CLK) disable iff (RST) // R12
    IMP_LOOPBACK[0] |-> IMP_GAIN_CH0 == '0)
    else $error("loopback code gain wrong");
  // R20: activate sets activity
  a_active_cmd: assert property (@(posedge REF_CLK) disable iff (RST) // R20
    CMD_VALID && CMD_CHANNEL && CMD_CODE == CMD_ACTIVATE |=> CHANNEL_ACTIVE[1] ##1 CHANNEL_ACTIVE[1]
      || $past(CMD_VALID))
    else $error("activate not taken");
  // R12: cutoff code gives zero gain
  a_cut_gain: assert property (@(posedge REF_CLK) disable iff (RST) // R12
    IMP_CUTOFF[0] |-> IMP_GAIN_CH0 == '0)
    else $error("cutoff code gain wrong");
  // R15: latch write reaches outputs
  a_latch_out: assert property (@(posedge REF_CLK) disable iff (RST) // R15
    CMD_VALID && !CMD_CHANNEL && CMD_CODE == CMD_WR_PIN_LATCH |=>
    LINE_PIN_CH0_OUT == $past(CMD_WDATA[NUM_LINE_PINS-1:0]))
    else $error("pin latch not applied");
  // R20: status read shows activity
  a_status_read: assert property (@(posedge REF_CLK) disable iff (RST) // R20
    CMD_VALID && CMD_CHANNEL && CMD_CODE == CMD_RD_DIR_STATUS |=>
    CMD_RVALID && CMD_RDATA[ACTIVITY_BIT] == $past(CHANNEL_ACTIVE[1]))
    else $error("activity bit read wrong");
  // R10: soft reset clears gains, keeps delay
  a_soft_gains: assert property (@(posedge REF_CLK) disable iff (RST) // R10
    CMD_VALID && !CMD_CHANNEL && CMD_CODE == CMD_SOFT_RESET |=> !TX_GAIN_6DB[0] &&
    !RX_LOSS_6DB[0] && IMP_CUTOFF[0] && DELAY_REMOVED[0] == $past(DELAY_REMOVED[0]))
    else $error("soft reset gains wrong");
  // R22: enables stored as written
  a_op_write: assert property (@(posedge REF_CLK) disable iff (RST) // R22
    CMD_VALID && CMD_CHANNEL && CMD_CODE == CMD_WR_OP_FUNC |=> OP_FUNC_CH1 == $past(CMD_WDATA))
    else $error("operating functions not stored");
  // R08: edge bit reads back
  a_clk_rd_edge: assert property (@(posedge REF_CLK) disable iff (RST) // R08
    CMD_VALID && CMD_CODE == CMD_RD_CLK_SLOT |=> CMD_RDATA[EDGE_BIT] == $past(TRANSMIT_EDGE_SELECT))
    else $error("edge bit read wrong");
  // R19: soft reset clears flag
  a_flag_clear: assert property (@(posedge REF_CLK) disable iff (RST) // R19
    CMD_VALID && !CMD_CHANNEL && CMD_CODE == CMD_SOFT_RESET && !power_sync_reg[1] |=>
    !power_flag_reg[0])
    else $error("power flag not cleared");
  // R01: slot write stored
  a_rx_slot_wr: assert property (@(posedge REF_CLK) disable iff (RST) // R01
    CMD_VALID && CMD_CHANNEL && CMD_CODE == CMD_WR_RX_SLOT |=> RX_SLOT_CH1 == $past(CMD_WDATA))
    else $error("receive slot not stored");
  // R19: directions read back
  a_dir_read: assert property (@(posedge REF_CLK) disable iff (RST) // R19
    CMD_VALID && !CMD_CHANNEL && CMD_CODE == CMD_RD_DIR_STATUS |=>
    CMD_RDATA[NUM_LINE_PINS-1:0] == ~$past(LINE_PIN_CH0_OE_N))
    else $error("direction read wrong");
endmodule

// file: host_cmd_model.sv
// Purpose: Host side of the command port, one command per call
// Assumes: Each command is launched just after a rising REF_CLK edge
// Notes: Code and data lines invert on release so stale values never help
`timescale 1ns/1ps
module host_cmd_model (
  input wire logic clk,
  output logic valid,
  output logic chan,
  output logic [7:0] code,
  output logic [7:0] wdata
);
  initial begin
    valid = 1'b0;
    chan = 1'b0;
    code = 8'h06;
    wdata = 8'h00;
  end
  // callers pass reserved bits as zero
  task automatic send(input logic ch, input logic [7:0] c, input logic [7:0] d);
    @(posedge clk);
    valid <= 1'b1;
    chan <= ch;
    code <= c;
    wdata <= d;
    @(posedge clk);
    valid <= 1'b0;
    code <= ~c;
    wdata <= ~d;
    // Settle past the taking edge so callers never race the update
    #1;
  endtask
endmodule

// file: line_codec_config_commands_bench.sv
// Purpose: Self-checking bench for the channel configuration commands
// Assumes: Reads answer in the cycle after the taking edge
// Notes: Pin inputs see the latch where driven, a fixed far-side level elsewhere
`timescale 1ns/1ps
module line_codec_config_commands_bench;
  import codec_cfg_pkg::*;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic ple = 1'b0;
  logic pcm = 1'b0;
  logic [4:0] ext0 = 5'h00;
  logic [4:0] ext1 = 5'h15;
  logic v, ch, rvalid, tes;
  logic [7:0] code, wd, rdata, slot0, slot1, opf0, opf1;
  logic [4:0] out0, oe0, out1, oe1, pin0, pin1;
  logic [1:0] act, dly, txg, rxl, lpb, cut, adp;
  logic [11:0] g0, g1;
  logic launch;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  initial forever #50 REF_CLK = ~REF_CLK;
  // Far side only drives pins that the device leaves as inputs
  assign pin0 = (oe0 & ext0) | (~oe0 & out0);
  assign pin1 = (oe1 & ext1) | (~oe1 & out1);
  host_cmd_model host (.clk(REF_CLK), .valid(v), .chan(ch), .code(code), .wdata(wd));
  line_codec_config_commands DUT (
    .REF_CLK(REF_CLK), .RST(RST), .CMD_VALID(v), .CMD_CHANNEL(ch),
    .CMD_CODE(code), .CMD_WDATA(wd), .CMD_RDATA(rdata), .CMD_RVALID(rvalid),
    .POWER_LOSS_EVENT(ple), .LINE_PIN_CH0_IN(pin0), .LINE_PIN_CH0_OUT(out0),
    .LINE_PIN_CH0_OE_N(oe0), .LINE_PIN_CH1_IN(pin1), .LINE_PIN_CH1_OUT(out1),
    .LINE_PIN_CH1_OE_N(oe1), .PCM_CLK(pcm), .PCM_TX_LAUNCH(launch),
    .TRANSMIT_EDGE_SELECT(tes), .CHANNEL_ACTIVE(act), .DELAY_REMOVED(dly),
    .TX_GAIN_6DB(txg), .RX_LOSS_6DB(rxl), .IMP_GAIN_CH0(g0), .IMP_GAIN_CH1(g1),
    .IMP_LOOPBACK(lpb), .IMP_CUTOFF(cut), .ADAPTIVE_ACTIVE(adp),
    .OP_FUNC_CH0(opf0), .OP_FUNC_CH1(opf1), .RX_SLOT_CH0(slot0), .RX_SLOT_CH1(slot1)
  );
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic chk_gain(input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // Answer must stand in the cycle after the taking edge
  task automatic rd(input logic c, input logic [7:0] op, input logic [7:0] exp);
    host.send(c, op, 8'h00);
    #1;
    chk_byte(exp, rvalid === 1'b1 ? rdata : 8'hXX);
  endtask
  task automatic t_reset();
    rd(1'b0, CMD_RD_DIR_STATUS, 8'h80);
    chk_byte(8'h1F, {3'h0, oe0});
    host.send(1'b0, CMD_SOFT_RESET, 8'h00);
    host.send(1'b1, CMD_SOFT_RESET, 8'h00);
    rd(1'b0, CMD_RD_DIR_STATUS, 8'h00);
  endtask
  task automatic t_slot();
    host.send(1'b0, CMD_WR_RX_SLOT, 8'hFF);
    host.send(1'b1, CMD_WR_RX_SLOT, 8'h00);
    rd(1'b0, CMD_RD_RX_SLOT, 8'hFF);
    rd(1'b1, CMD_RD_RX_SLOT, 8'h00);
    chk_byte(8'hFF, slot0);
    chk_byte(8'h00, slot1);
  endtask
  task automatic t_edge();
    host.send(1'b0, CMD_WR_DELAY_GAIN, 8'h80);
    host.send(1'b1, CMD_WR_DELAY_GAIN, 8'h80);
    host.send(1'b0, CMD_WR_CLK_SLOT, 8'h7F);
    rd(1'b0, CMD_RD_CLK_SLOT, 8'h7F);
    rd(1'b1, CMD_RD_CLK_SLOT, 8'h40);
    chk_byte(8'h01, {7'h00, tes});
    host.send(1'b1, CMD_WR_CLK_SLOT, 8'h2A);
    rd(1'b0, CMD_RD_CLK_SLOT, 8'h3F);
  endtask
  // Slow PCM clock keeps well under its ceiling
  task automatic t_pcm();
    int nr, nf;
    for (int s = 1; s >= 0; s--) begin
      host.send(1'b0, CMD_WR_CLK_SLOT, {1'b0, s[0], 6'h00});
      nr = 0;
      nf = 0;
      pcm <= 1'b1;
      repeat (6) @(posedge REF_CLK) nr += (launch === 1'b1);
      pcm <= 1'b0;
      repeat (6) @(posedge REF_CLK) nf += (launch === 1'b1);
      chk_byte(8'(s), 8'(nr));
      chk_byte(8'(1 - s), 8'(nf));
    end
  endtask
  task automatic t_gain();
    host.send(1'b0, CMD_WR_DELAY_GAIN, 8'hF0);
    rd(1'b0, CMD_RD_DELAY_GAIN, 8'hF0);
    chk_byte(8'h0F, {4'h0, dly[0], txg[0], rxl[0], lpb[0]});
    chk_byte(8'h00, {6'h00, txg[1], rxl[1]});
    host.send(1'b0, CMD_WR_DELAY_GAIN, 8'h1F);
    chk_gain(12'h00F, g0);
    host.send(1'b0, CMD_WR_DELAY_GAIN, 8'h01);
    chk_gain(12'hFF1, g0);
    host.send(1'b0, CMD_WR_DELAY_GAIN, 8'h00);
    chk_byte(8'h01, {6'h00, lpb[0], cut[0]});
    chk_gain(12'h000, g0);
    chk_gain(12'h000, g1);
  endtask
  task automatic t_pins();
    logic [4:0] dir, lat;
    dir = 5'h15;
    lat = 5'h0F;
    host.send(1'b0, CMD_WR_PIN_DIR, {3'h0, dir});
    host.send(1'b0, CMD_WR_PIN_LATCH, {3'h0, lat});
    chk_byte({3'h0, ~dir}, {3'h0, oe0});
    chk_byte({3'h0, lat}, {3'h0, out0});
    chk_byte(8'h1F, {3'h0, oe1});
    repeat (4) @(posedge REF_CLK);
    rd(1'b0, CMD_RD_PIN_LEVELS, {3'h0, (lat & dir) | (ext0 & ~dir)});
    rd(1'b1, CMD_RD_PIN_LEVELS, {3'h0, ext1});
    rd(1'b0, CMD_RD_DIR_STATUS, {3'h0, dir});
  endtask
  task automatic t_ops();
    host.send(1'b1, CMD_WR_OP_FUNC, 8'hA5);
    rd(1'b1, CMD_RD_OP_FUNC, 8'hA5);
    chk_byte(8'hA5, opf1);
    chk_byte(8'h00, opf0);
    chk_byte(8'h02, {6'h00, adp});
    host.send(1'b1, CMD_WR_OP_FUNC, 8'hC0);
    chk_byte(8'h00, {6'h00, adp});
    rd(1'b1, CMD_RD_OP_FUNC, 8'hC0);
  endtask
  task automatic t_act();
    host.send(1'b1, CMD_ACTIVATE, 8'h00);
    chk_byte(8'h02, {6'h00, act});
    rd(1'b1, CMD_RD_DIR_STATUS, 8'h40);
    host.send(1'b1, CMD_DEACTIVATE, 8'h00);
    chk_byte(8'h00, {6'h00, act});
  endtask
  task automatic t_event();
    ple <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    ple <= 1'b0;
    repeat (5) @(posedge REF_CLK);
    rd(1'b0, CMD_RD_DIR_STATUS, 8'h95);
    host.send(1'b0, 8'h73, 8'h00);
    #1;
    chk_byte(8'h00, {7'h00, rvalid});
  endtask
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge REF_CLK);
    RST <= 1'b0;
    t_reset();
    t_slot();
    t_edge();
    t_pcm();
    t_gain();
    t_pins();
    t_ops();
    t_act();
    t_event();
    close_out();
  end
endmodule
